// ===== hdl/vpa_pkg.sv
package vpa_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int          PIN_N       = 8;
	localparam int          AW          = 8;
	localparam int          DW          = 32;
	localparam int          BYTE_SHIFT  = 2;
	localparam int          SETUP_LSB   = 5;

	// ----------------------------------------------------------------
	// Register indices, byte address is index times four
	// ----------------------------------------------------------------
	localparam logic [AW-1:0] IDX_DRIVE_EN   = 8'h00;
	localparam logic [AW-1:0] IDX_DRIVE_LVL  = 8'h01;
	localparam logic [AW-1:0] IDX_SAMPLED    = 8'h02;
	localparam logic [AW-1:0] IDX_FLAGS      = 8'h03;
	localparam logic [AW-1:0] IDX_EVT_STATUS = 8'h04;
	localparam logic [AW-1:0] IDX_EVT_MASK   = 8'h05;
	localparam logic [AW-1:0] IDX_SETUP_BASE = 8'h10;

	localparam logic [AW-1:0] ADDR_DRIVE_EN   = IDX_DRIVE_EN << BYTE_SHIFT;
	localparam logic [AW-1:0] ADDR_DRIVE_LVL  = IDX_DRIVE_LVL << BYTE_SHIFT;
	localparam logic [AW-1:0] ADDR_SAMPLED    = IDX_SAMPLED << BYTE_SHIFT;
	localparam logic [AW-1:0] ADDR_FLAGS      = IDX_FLAGS << BYTE_SHIFT;
	localparam logic [AW-1:0] ADDR_EVT_STATUS = IDX_EVT_STATUS << BYTE_SHIFT;
	localparam logic [AW-1:0] ADDR_EVT_MASK   = IDX_EVT_MASK << BYTE_SHIFT;
	localparam logic [AW-1:0] ADDR_SETUP_BASE = IDX_SETUP_BASE << BYTE_SHIFT;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [7:0]  RST_MASK    = 8'hFF;
	localparam logic [23:0] RD_PAD      = 24'h00_0000;

	// ----------------------------------------------------------------
	// Per-pin setup layout and sense codes
	// ----------------------------------------------------------------
	localparam int          POL_BIT     = 7;
	localparam int          PULL_BIT    = 3;
	localparam int          SENSE_LSB   = 0;
	localparam int          SENSE_W     = 3;
	localparam logic [7:0]  SETUP_WMASK = 8'h8F;

	localparam logic [SENSE_W-1:0] SENSE_NOINT = 3'h0;
	localparam logic [SENSE_W-1:0] SENSE_BOTH  = 3'h1;
	localparam logic [SENSE_W-1:0] SENSE_RISE  = 3'h2;
	localparam logic [SENSE_W-1:0] SENSE_FALL  = 3'h3;
	localparam logic [SENSE_W-1:0] SENSE_OFF   = 3'h4;
	localparam logic [SENSE_W-1:0] SENSE_LOW   = 3'h5;

endpackage

// ===== hdl/vpa_sense_if.sv
`timescale 1ns/100ps
interface vpa_sense_if;
	logic [vpa_pkg::PIN_N-1:0][vpa_pkg::SENSE_W-1:0] sense_cfg;
	logic [vpa_pkg::PIN_N-1:0]                       pol;
	logic [vpa_pkg::PIN_N-1:0]                       pin_sync;
	logic [vpa_pkg::PIN_N-1:0]                       sampled;
	logic [vpa_pkg::PIN_N-1:0]                       event_pulse;

	modport core  (output sense_cfg, output pol, output pin_sync,
	               input sampled, input event_pulse);
	modport sense (input sense_cfg, input pol, input pin_sync,
	               output sampled, output event_pulse);
endinterface

// ===== hdl/vpa_pin_sense.sv
`timescale 1ns/100ps
module vpa_pin_sense (
	input  wire logic  mclk,
	input  wire logic  rst_n,
	vpa_sense_if.sense sif
);
	// ----------------------------------------------------------------
	// Per-pin sampling and edge/level sense
	// ----------------------------------------------------------------
	logic [vpa_pkg::PIN_N-1:0] sampled_ff;
	logic [vpa_pkg::PIN_N-1:0] nxt_sampled;
	logic [vpa_pkg::PIN_N-1:0] evt;

	genvar g;
	generate
		for (g = 0; g < vpa_pkg::PIN_N; g++) begin : g_pin
			logic buf_on;
			logic in_val;
			// Buffer gate and polarity, no dependence on drive enable
			assign buf_on = (sif.sense_cfg[g] != vpa_pkg::SENSE_OFF);
			assign in_val = sif.pin_sync[g] ^ sif.pol[g];

			// Hold last value while buffer is off
			always_comb begin
				nxt_sampled[g] = buf_on ? in_val : sampled_ff[g];
				unique case (sif.sense_cfg[g])
					vpa_pkg::SENSE_BOTH: evt[g] = in_val ^ sampled_ff[g];
					vpa_pkg::SENSE_RISE: evt[g] = in_val & ~sampled_ff[g];
					vpa_pkg::SENSE_FALL: evt[g] = ~in_val & sampled_ff[g];
					vpa_pkg::SENSE_LOW:  evt[g] = ~in_val;
					default:             evt[g] = 1'b0; // No-int, off, reserved
				endcase
			end
		end
	endgenerate

	// Sample register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sampled_ff <= vpa_pkg::RST_BYTE;
		end else begin
			sampled_ff <= nxt_sampled;
		end
	end

	assign sif.sampled     = sampled_ff;
	assign sif.event_pulse = evt;
endmodule

// ===== hdl/vpa_port.sv
// How it works
// - Drive-enable bit turns pin driver on
// - Drive enable never gates input buffer
// - Level reaches pin only when driven
// - Sampled register returns pin levels
// - Disabled buffer holds sampled bit
// - Writing one to sampled toggles level
// - Sense match sets pin event flag
// - Writing one clears an event flag
// - Three-bit sense code selects behaviour
// - Polarity flips sampled and driven value
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
module vpa_port (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [7:0]        pin_in,
	output logic      [7:0]        pin_out,
	output logic      [7:0]        pin_oe,
	output logic      [7:0]        pin_pullup,
	output logic                   irq
);
	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_ff;
	logic rst_s_ff;

	// Two-stage release of the async reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_s_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_s_ff    <= rst_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	logic [7:0] pin_meta_ff;
	logic [7:0] pin_sync_ff;

	// Two flops before any sense logic
	always_ff @(posedge mclk or negedge rst_s_ff) begin
		if (!rst_s_ff) begin
			pin_meta_ff <= vpa_pkg::RST_BYTE;
			pin_sync_ff <= vpa_pkg::RST_BYTE;
		end else begin
			pin_meta_ff <= pin_in;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]  drive_en_ff,   nxt_drive_en;
	logic [7:0]  drive_lvl_ff,  nxt_drive_lvl;
	logic [7:0]  flags_ff,      nxt_flags;
	logic [7:0]  evt_status_ff, nxt_evt_status;
	logic [7:0]  evt_mask_ff,   nxt_evt_mask;
	logic [7:0]  setup_ff [vpa_pkg::PIN_N];
	logic [7:0]  nxt_setup [vpa_pkg::PIN_N];
	logic [31:0] prdata_ff,     nxt_prdata;
	logic [7:0]  pin_out_ff,    nxt_pin_out;
	logic [7:0]  pin_oe_ff,     nxt_pin_oe;
	logic [7:0]  pullup_ff,     nxt_pullup;
	logic [7:0]  int_en;
	logic [7:0]  rd_byte;
	logic        hit;
	logic        setup_hit;
	logic [2:0]  setup_idx;
	logic        access;
	logic        wr_en;
	logic        rd_done;

	vpa_sense_if sif ();

	vpa_pin_sense vpa_pin_sense_i (
		.mclk  (mclk),
		.rst_n (rst_s_ff),
		.sif   (sif.sense)
	);

	// ----------------------------------------------------------------
	// Setup fields to the sense block
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < vpa_pkg::PIN_N; g++) begin : g_cfg
			assign sif.sense_cfg[g] =
				setup_ff[g][vpa_pkg::SENSE_LSB +: vpa_pkg::SENSE_W];
			assign sif.pol[g] = setup_ff[g][vpa_pkg::POL_BIT];
			// Sense codes that raise an interrupt
			assign int_en[g] = (sif.sense_cfg[g] == vpa_pkg::SENSE_BOTH)
				|| (sif.sense_cfg[g] == vpa_pkg::SENSE_RISE)
				|| (sif.sense_cfg[g] == vpa_pkg::SENSE_FALL)
				|| (sif.sense_cfg[g] == vpa_pkg::SENSE_LOW);
		end
	endgenerate
	assign sif.pin_sync = pin_sync_ff;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Port registers at the six lowest indices, setup bytes from index 16
	always_comb begin
		setup_hit = (paddr[vpa_pkg::AW-1:vpa_pkg::SETUP_LSB]
			== vpa_pkg::ADDR_SETUP_BASE[vpa_pkg::AW-1:vpa_pkg::SETUP_LSB])
			&& (paddr[vpa_pkg::BYTE_SHIFT-1:0] == 2'b00);
		setup_idx = paddr[vpa_pkg::SETUP_LSB-1:vpa_pkg::BYTE_SHIFT];
		hit       = setup_hit;
		rd_byte   = vpa_pkg::RST_BYTE;
		unique case (paddr)
			vpa_pkg::ADDR_DRIVE_EN: begin
				hit     = 1'b1;
				rd_byte = drive_en_ff;
			end
			vpa_pkg::ADDR_DRIVE_LVL: begin
				hit     = 1'b1;
				rd_byte = drive_lvl_ff;
			end
			vpa_pkg::ADDR_SAMPLED: begin
				hit     = 1'b1;
				rd_byte = sif.sampled;
			end
			vpa_pkg::ADDR_FLAGS: begin
				hit     = 1'b1;
				rd_byte = flags_ff;
			end
			vpa_pkg::ADDR_EVT_STATUS: begin
				hit     = 1'b1;
				rd_byte = evt_status_ff;
			end
			vpa_pkg::ADDR_EVT_MASK: begin
				hit     = 1'b1;
				rd_byte = evt_mask_ff;
			end
			default: begin
				if (setup_hit) begin
					rd_byte = setup_ff[setup_idx];
				end
			end
		endcase
	end

	// Zero-wait slave, error on unmapped address
	assign access  = psel & penable;
	assign pready  = 1'b1;
	assign pslverr = access & ~hit;
	assign wr_en   = access & pwrite & hit & pstrb[0];
	assign rd_done = access & ~pwrite & (paddr == vpa_pkg::ADDR_EVT_STATUS);

	// ----------------------------------------------------------------
	// Register next values
	// ----------------------------------------------------------------
	// Shared state: one copy behind every access path
	always_comb begin
		nxt_drive_en  = drive_en_ff;
		nxt_drive_lvl = drive_lvl_ff;
		nxt_evt_mask  = evt_mask_ff;
		nxt_flags     = flags_ff;
		nxt_setup     = setup_ff;
		nxt_prdata    = prdata_ff;
		if (psel && !penable) begin
			nxt_prdata = {vpa_pkg::RD_PAD, rd_byte};
		end
		if (wr_en) begin
			unique case (paddr)
				vpa_pkg::ADDR_DRIVE_EN:  nxt_drive_en  = pwdata[7:0];
				vpa_pkg::ADDR_DRIVE_LVL: nxt_drive_lvl = pwdata[7:0];
				vpa_pkg::ADDR_SAMPLED:   nxt_drive_lvl = drive_lvl_ff ^ pwdata[7:0];
				vpa_pkg::ADDR_FLAGS:     nxt_flags     = flags_ff & ~pwdata[7:0];
				vpa_pkg::ADDR_EVT_MASK:  nxt_evt_mask  = pwdata[7:0];
				default: begin
					if (setup_hit) begin
						nxt_setup[setup_idx] = pwdata[7:0] & vpa_pkg::SETUP_WMASK;
					end
				end
			endcase
		end
		// Hardware set wins over a same-cycle clear
		nxt_flags      = nxt_flags | sif.event_pulse;
		// Read clears only the bits actually returned
		nxt_evt_status = (evt_status_ff & ~(rd_done ? prdata_ff[7:0] : vpa_pkg::RST_BYTE))
			| sif.event_pulse;
	end

	// Pin drive and pull-up from the next register values
	always_comb begin
		for (int i = 0; i < vpa_pkg::PIN_N; i++) begin
			nxt_pin_oe[i]  = nxt_drive_en[i];
			nxt_pin_out[i] = (nxt_drive_lvl[i] ^ nxt_setup[i][vpa_pkg::POL_BIT])
				& nxt_drive_en[i];
			nxt_pullup[i]  = nxt_setup[i][vpa_pkg::PULL_BIT] & ~nxt_drive_en[i];
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_s_ff) begin
		if (!rst_s_ff) begin
			drive_en_ff   <= vpa_pkg::RST_BYTE;
			drive_lvl_ff  <= vpa_pkg::RST_BYTE;
			flags_ff      <= vpa_pkg::RST_BYTE;
			evt_status_ff <= vpa_pkg::RST_BYTE;
			evt_mask_ff   <= vpa_pkg::RST_MASK;
			prdata_ff     <= {vpa_pkg::RD_PAD, vpa_pkg::RST_BYTE};
			pin_out_ff    <= vpa_pkg::RST_BYTE;
			pin_oe_ff     <= vpa_pkg::RST_BYTE;
			pullup_ff     <= vpa_pkg::RST_BYTE;
			for (int i = 0; i < vpa_pkg::PIN_N; i++) begin
				setup_ff[i] <= vpa_pkg::RST_BYTE;
			end
		end else begin
			drive_en_ff   <= nxt_drive_en;
			drive_lvl_ff  <= nxt_drive_lvl;
			flags_ff      <= nxt_flags;
			evt_status_ff <= nxt_evt_status;
			evt_mask_ff   <= nxt_evt_mask;
			prdata_ff     <= nxt_prdata;
			pin_out_ff    <= nxt_pin_out;
			pin_oe_ff     <= nxt_pin_oe;
			pullup_ff     <= nxt_pullup;
			setup_ff      <= nxt_setup;
		end
	end

	// Outputs
	assign prdata     = prdata_ff;
	assign pin_out    = pin_out_ff;
	assign pin_oe     = pin_oe_ff;
	assign pin_pullup = pullup_ff;
	// Enabled flags or unread status, gated by mask
	assign irq = |(((flags_ff & int_en) | evt_status_ff) & evt_mask_ff);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_s_ff);

	property p_drive_en_write;
		(wr_en && paddr == vpa_pkg::ADDR_DRIVE_EN) |=> (pin_oe == $past(pwdata[7:0]));
	endproperty
	a_drive_en_write: assert property (p_drive_en_write)
		else $error("drive enable write did not reach pin_oe");

	property p_level_write;
		(wr_en && paddr == vpa_pkg::ADDR_DRIVE_LVL) |=> (drive_lvl_ff == $past(pwdata[7:0]));
	endproperty
	a_level_write: assert property (p_level_write)
		else $error("drive level write lost");

	property p_toggle;
		(wr_en && paddr == vpa_pkg::ADDR_SAMPLED)
			|=> (drive_lvl_ff == ($past(drive_lvl_ff) ^ $past(pwdata[7:0])));
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("sampled write did not toggle level");

	property p_flag_clear;
		(wr_en && paddr == vpa_pkg::ADDR_FLAGS)
			|=> ((flags_ff & $past(pwdata[7:0]) & ~$past(sif.event_pulse)) == 8'h00);
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("flag not cleared by write of one");

	property p_flag_set;
		(sif.event_pulse != 8'h00)
			|=> ((flags_ff & $past(sif.event_pulse)) == $past(sif.event_pulse));
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("sense event did not set flag");

	property p_irq_hold;
		((sif.event_pulse & int_en & evt_mask_ff) != 8'h00)
			&& !(wr_en && paddr == vpa_pkg::ADDR_EVT_MASK) |=> irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("irq low after enabled sense event");

	property p_irq_stay;
		(irq && !access) |=> irq;
	endproperty
	a_irq_stay: assert property (p_irq_stay)
		else $error("irq dropped without any bus access");

	property p_buf_off_hold;
		(sif.sense_cfg[0] == vpa_pkg::SENSE_OFF) ##1 (sif.sense_cfg[0] == vpa_pkg::SENSE_OFF)
			|-> $stable(sif.sampled[0]);
	endproperty
	a_buf_off_hold: assert property (p_buf_off_hold)
		else $error("sampled bit changed with buffer off");

	property p_sample_track;
		(pin_in[0] && sif.sense_cfg[0] == vpa_pkg::SENSE_NOINT && !sif.pol[0])[*4]
			|-> sif.sampled[0];
	endproperty
	a_sample_track: assert property (p_sample_track)
		else $error("sampled bit does not follow pin after sync");

	property p_pol_out;
		(pin_oe[0] && setup_ff[0][vpa_pkg::POL_BIT]) |-> (pin_out[0] == ~drive_lvl_ff[0]);
	endproperty
	a_pol_out: assert property (p_pol_out)
		else $error("polarity flip not applied to output");
endmodule

// ===== verification/vpa_pin_model.sv
`timescale 1ns/100ps
module vpa_pin_model (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pullup,
	input  wire logic [7:0] ext_lvl,
	input  wire logic [7:0] ext_en,
	output logic      [7:0] pin_lvl
);
	logic [7:0] last_ff;
	logic [7:0] driven;

	assign driven = pin_oe | ext_en;

	// Last level put on each line by a driver
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			last_ff <= 8'h00;
		end else begin
			last_ff <= (driven & pin_lvl) | (~driven & last_ff);
		end
	end

	// Wire level resolved from every party that may drive it
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i]) begin
				pin_lvl[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_lvl[i] = ext_lvl[i];
			end else if (pin_pullup[i]) begin
				pin_lvl[i] = 1'b1;
			end else begin
				pin_lvl[i] = ~last_ff[i]; // Released line drifts to the inverse
			end
		end
	end
endmodule

// ===== verification/vpa_port_tb_top.sv
`timescale 1ns/100ps
module vpa_port_tb_top;
	localparam logic [7:0] A_EN = vpa_pkg::ADDR_DRIVE_EN;
	localparam logic [7:0] A_LV = vpa_pkg::ADDR_DRIVE_LVL;
	localparam logic [7:0] A_SM = vpa_pkg::ADDR_SAMPLED;
	localparam logic [7:0] A_FL = vpa_pkg::ADDR_FLAGS;
	localparam logic [7:0] A_ST = vpa_pkg::ADDR_EVT_STATUS;
	localparam logic [7:0] A_MK = vpa_pkg::ADDR_EVT_MASK;
	localparam logic [7:0] A_SU = vpa_pkg::ADDR_SETUP_BASE;

	logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0]  paddr, ext_lvl, pin_in, pin_out, pin_oe, pin_pullup;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, strb;
	int          error_cnt, compares;

	vpa_port vpa_port_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup(pin_pullup), .irq(irq));

	vpa_pin_model vpa_pin_model_i (.mclk(mclk), .rst_n(rst_n), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup(pin_pullup), .ext_lvl(ext_lvl), .ext_en(8'h0F),
		.pin_lvl(pin_in));

	// ----------------------------------------------------------------
	// Bus tasks and checks
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One transfer: setup, then access held until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pstrb <= strb;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("CHECK FAILED pready expected 1 seen %b", pready);
			complete_run();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, exp, rd);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Clock, 10 ns period
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		$display("CHECK FAILED run timeout");
		complete_run();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0]  ra [7];
		logic [7:0]  rv [7];
		logic [7:0]  sc [4];
		ra = '{A_EN, A_LV, A_SM, A_FL, A_ST, A_MK, A_SU};
		rv = '{8'h00, 8'h00, 8'hF0, 8'h00, 8'h00, 8'hFF, 8'h00}; // Undriven pins 7:4 idle high
		sc = '{8'h02, 8'h03, 8'h01, 8'h08};
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		strb = 4'hF;
		ext_lvl = 8'h00;
		error_cnt = 0;
		compares = 0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		cyc(4);
		// Reset values and an unmapped place
		for (int i = 0; i < 7; i++) begin
			rdc("reset value", ra[i], {24'h00_0000, rv[i]});
		end
		rdc("unmapped data", 8'h20, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
		$display("Test reset done");
		// Driver enable, level, ignored strobe, toggle through sampled
		wr(A_EN, 32'h0000_00F0);
		wr(A_LV, 32'h0000_00A5);
		cyc(2);
		chk("pin_oe", 32'h0000_00F0, {24'h00_0000, pin_oe});
		chk("pin_out", 32'h0000_00A0, {24'h00_0000, pin_out});
		strb = 4'h0;
		wr(A_LV, 32'h0000_00FF);
		strb = 4'hF;
		rdc("level strobe", A_LV, 32'h0000_00A5);
		wr(A_SM, 32'h0000_0030);
		wr(A_SM, 32'h0000_0000);
		rdc("level toggle", A_LV, 32'h0000_0095);
		cyc(2);
		chk("pin_out toggle", 32'h0000_0090, {24'h00_0000, pin_out});
		$display("Test drive done");
		// Sampling of port-driven and externally driven pins, then polarity
		ext_lvl <= 8'h06;
		cyc(5);
		rdc("sampled", A_SM, 32'h0000_0096);
		wr(A_SU + 8'h10, 32'h0000_0080);
		cyc(5);
		chk("pin_out polarity", 32'h0000_0080, {24'h00_0000, pin_out});
		rdc("sampled polarity", A_SM, 32'h0000_0096);
		$display("Test sample done");
		// Edge senses, flags, status, mask and irq
		ext_lvl <= 8'h00;
		cyc(5);
		for (int i = 0; i < 4; i++) begin
			wr(A_SU + 8'(4 * i), {24'h00_0000, sc[i]});
		end
		wr(A_FL, 32'h0000_00FF);
		apb(1'b0, A_ST, 32'h0000_0000);
		cyc(2);
		chk("pullup", 32'h0000_0008, {24'h00_0000, pin_pullup});
		chk("irq idle", 32'h0000_0000, {31'h0000_0000, irq});
		ext_lvl <= 8'h0F;
		cyc(5);
		rdc("flags rise", A_FL, 32'h0000_0005);
		chk("irq set", 32'h0000_0001, {31'h0000_0000, irq});
		ext_lvl <= 8'h00;
		cyc(5);
		rdc("flags fall", A_FL, 32'h0000_0007);
		wr(A_FL, 32'h0000_0001);
		wr(A_FL, 32'h0000_0000);
		rdc("flags clear", A_FL, 32'h0000_0006);
		wr(A_MK, 32'h0000_0000);
		cyc(2);
		chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
		wr(A_MK, 32'h0000_00FF);
		cyc(2);
		chk("irq unmasked", 32'h0000_0001, {31'h0000_0000, irq});
		rdc("status", A_ST, 32'h0000_0007);
		rdc("status cleared", A_ST, 32'h0000_0000);
		wr(A_FL, 32'h0000_00FF);
		cyc(2);
		chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
		$display("Test edge done");
		// Buffer off holds the bit, low level keeps setting
		wr(A_SU, 32'h0000_0004);
		ext_lvl <= 8'h01;
		cyc(5);
		rdc("sampled held", A_SM, 32'h0000_0090);
		rdc("flags off", A_FL, 32'h0000_0000);
		wr(A_SU + 8'h04, 32'h0000_0005);
		cyc(4);
		wr(A_FL, 32'h0000_00FF);
		rdc("flags level", A_FL, 32'h0000_0002);
		chk("irq level", 32'h0000_0001, {31'h0000_0000, irq});
		ext_lvl <= 8'h03;
		cyc(5);
		wr(A_FL, 32'h0000_00FF);
		apb(1'b0, A_ST, 32'h0000_0000);
		rdc("flags high", A_FL, 32'h0000_0000);
		cyc(2);
		chk("irq released", 32'h0000_0000, {31'h0000_0000, irq});
		$display("Test sense done");
		complete_run();
	end
endmodule
